// [rtl/cso_sense_ctrl.v]
// Sense output control: configuration words, watchdog, fail-safe,
// channel switching and sense output selection with blanking.
// Assumes pins arrive asynchronous; current and temperature codes
// come digitised on sys_clk from the analog front end.
`timescale 1ns/1ps
`include "cso_defines.vh"

module cso_sense_ctrl #(
	parameter [`CSO_WDTO_W-1:0]    WDTO_CYC    = `CSO_WDTO_CYC,
	parameter [`CSO_OC_UNIT_W-1:0] OC_UNIT_CYC = `CSO_OC_UNIT_CYC
) (
	input  wire                   sys_clk,       // System clock, 100 MHz
	input  wire                   reset,         // Sync reset, active high
	input  wire                   chip_reset_n,  // Chip reset pin, active low
	input  wire                   spi_sclk,      // Serial clock pin
	input  wire                   select_n,      // Chip select pin, active low
	input  wire                   spi_si,        // Serial data pin
	input  wire [1:0]             direct_in,     // Direct input pins
	input  wire                   ext_clk,       // External PWM clock pin
	input  wire                   vdd_present,   // Digital supply present pin
	input  wire [`CSO_CODE_W-1:0] current_code0, // Channel 0 current code
	input  wire [`CSO_CODE_W-1:0] current_code1, // Channel 1 current code
	input  wire [`CSO_CODE_W-1:0] temp_code,     // Die temperature code
	output wire [1:0]             switch_output, // Channel gate drive
	output reg                    fail_safe,     // Fail-safe mode active
	output reg                    sense_oe,      // Sense output driven
	output reg  [1:0]             sense_sel,     // Analog mux selection
	output reg  [`CSO_CODE_W-1:0] sense_value,   // Value on sense output
	output wire [1:0]             oc_window,     // Overcurrent windows
	output wire [`CSO_CODE_W-1:0] oc_thresh0,    // Channel 0 threshold
	output wire [`CSO_CODE_W-1:0] oc_thresh1     // Channel 1 threshold
);

	// ==========================================
	// Declarations
	wire                     word_valid;
	wire [`CSO_WORD_W-1:0]   word_data;
	wire [3:0]               word_addr;
	wire [`CSO_DATA_W-1:0]   word_val;
	wire                     word_take;
	reg                      rstn_m_q, rstn_s_q, rstn_p_q;
	reg [1:0]                din_m_q, din_s_q;
	reg                      ext_m_q, ext_s_q, ext_p_q;
	reg                      vdd_m_q, vdd_s_q;
	reg [`CSO_RST_CNT_W-1:0] rst_low_q;
	wire                     rst_rise;
	wire                     cfg_clear;
	reg [`CSO_DATA_W-1:0]    gcr_q;
	reg                      wd_arm_q;
	reg                      tog_seen_q;
	reg                      tog_ref_q;
	reg [`CSO_WDTO_W-1:0]    wd_cnt_q;
	wire                     wd_kick;
	wire                     wd_expire;
	reg [7:0]                pre_q;
	reg [3:0]                int_phase_q;
	reg [3:0]                ext_phase_q;
	wire [2*`CSO_CODE_W-1:0] cur_all;
	wire [2*`CSO_CODE_W-1:0] present_all;
	wire [2*`CSO_CODE_W-1:0] thresh_all;
	wire [1:0]               sel_cfg;
	wire                     blank;

	assign word_addr = word_data[`CSO_ADDR_HI:`CSO_ADDR_LO];
	assign word_val  = word_data[`CSO_DATA_W-1:0];
	assign word_take = word_valid & rstn_s_q;
	assign cur_all   = {current_code1, current_code0};
	assign rst_rise  = ~rstn_p_q & rstn_s_q;
	assign cfg_clear = ~rstn_s_q && (rst_low_q == `CSO_RST_MIN_CYC);

	// ==========================================
	// Serial word receiver
	cso_spi_rx u_rx (
		.sys_clk    (sys_clk),
		.reset      (reset),
		.spi_sclk   (spi_sclk),
		.select_n   (select_n),
		.spi_si     (spi_si),
		.word_valid (word_valid),
		.word_data  (word_data)
	);

	// ==========================================
	// Pin synchronisers, two flops each; chip reset and ext_clk add a third for edge detect
	always @(posedge sys_clk) begin
		if (reset) begin
			{rstn_m_q, rstn_s_q, rstn_p_q} <= 3'h0;
			din_m_q  <= 2'h0;
			din_s_q  <= 2'h0;
			{ext_m_q, ext_s_q, ext_p_q}    <= 3'h0;
			{vdd_m_q, vdd_s_q}             <= 2'h0;
		end else begin
			rstn_m_q <= chip_reset_n;
			rstn_s_q <= rstn_m_q;
			rstn_p_q <= rstn_s_q;
			din_m_q  <= direct_in;
			din_s_q  <= din_m_q;
			ext_m_q  <= ext_clk;
			ext_s_q  <= ext_m_q;
			ext_p_q  <= ext_s_q;
			vdd_m_q  <= vdd_present;
			vdd_s_q  <= vdd_m_q;
		end
	end

	// Chip reset low-time filter; short glitches leave config alone
	always @(posedge sys_clk) begin
		if (reset) begin
			rst_low_q <= {`CSO_RST_CNT_W{1'b0}};
		end else if (rstn_s_q) begin
			rst_low_q <= {`CSO_RST_CNT_W{1'b0}};
		end else if (rst_low_q != `CSO_RST_MIN_CYC) begin
			rst_low_q <= rst_low_q + 1'b1;
		end
	end

	// ==========================================
	// Global configuration word
	always @(posedge sys_clk) begin
		if (reset || cfg_clear) begin
			gcr_q <= `CSO_GCR_RST;
		end else if (word_take && word_addr == `CSO_ADDR_GCR) begin
			gcr_q <= word_val;
		end
	end

	// ==========================================
	// Watchdog on the alternating first word bit
	// First word after release loads the reference and also counts as a kick
	assign wd_kick = word_take &&
		(!tog_seen_q || word_data[`CSO_TOG_BIT] != tog_ref_q);
	assign wd_expire = wd_arm_q && !gcr_q[`CSO_GCR_WD_OFF] &&
		(wd_cnt_q == WDTO_CYC - 1'b1);

	always @(posedge sys_clk) begin
		if (reset || !rstn_s_q) begin
			wd_arm_q   <= 1'b0;
			tog_seen_q <= 1'b0;
			tog_ref_q  <= 1'b0;
			wd_cnt_q   <= {`CSO_WDTO_W{1'b0}};
		end else begin
			if (rst_rise) begin
				wd_arm_q <= 1'b1;
			end
			if (wd_kick) begin
				tog_seen_q <= 1'b1;
				tog_ref_q  <= word_data[`CSO_TOG_BIT];
			end
			// Counter held at zero while disabled, frozen once in fail-safe
			if (rst_rise || wd_kick || gcr_q[`CSO_GCR_WD_OFF]) begin
				wd_cnt_q <= {`CSO_WDTO_W{1'b0}};
			end else if (wd_arm_q && !fail_safe) begin
				wd_cnt_q <= wd_cnt_q + 1'b1;
			end
		end
	end

	// Fail-safe holds until the chip reset pin goes low
	// No software exit: a lost host could not be trusted to clear it
	always @(posedge sys_clk) begin
		if (reset || !rstn_s_q) begin
			fail_safe <= 1'b0;
		end else if (wd_expire) begin
			fail_safe <= 1'b1;
		end
	end

	// ==========================================
	// Shared PWM phase: internal prescaled, external edge counted
	always @(posedge sys_clk) begin
		if (reset) begin
			pre_q       <= 8'h00;
			int_phase_q <= 4'h0;
			ext_phase_q <= 4'h0;
		end else begin
			if (pre_q == `CSO_PWM_TICK - 8'h01) begin
				pre_q       <= 8'h00;
				int_phase_q <= int_phase_q + 4'h1;
			end else begin
				pre_q <= pre_q + 8'h01;
			end
			if (ext_s_q && !ext_p_q) begin
				ext_phase_q <= ext_phase_q + 4'h1;
			end
		end
	end

	// ==========================================
	// Per-channel config, switching, hold and profile
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_ch
			// Word addresses per channel, kept at the 4-bit width of word_addr
			localparam [3:0] CH_ADDR = (g == 0) ? `CSO_ADDR_CH0 : `CSO_ADDR_CH0 + 4'h1;
			localparam [3:0] OC_ADDR = (g == 0) ? `CSO_ADDR_OC0 : `CSO_ADDR_OC0 + 4'h1;
			reg [`CSO_DATA_W-1:0]  cfg_q;
			reg [`CSO_DATA_W-1:0]  occ_q;
			reg                    sw_q;
			reg                    want;
			reg [`CSO_CODE_W-1:0]  held_q;
			wire [1:0]             mode;
			wire [3:0]             duty;
			wire                   spi_on;
			wire [`CSO_CODE_W-1:0] cur;

			assign mode   = cfg_q[`CSO_CH_MODE_HI:`CSO_CH_MODE_LO];
			assign duty   = cfg_q[`CSO_CH_DUTY_HI:`CSO_CH_DUTY_LO];
			assign spi_on = cfg_q[`CSO_CH_ON];
			assign cur    = cur_all[g*`CSO_CODE_W +: `CSO_CODE_W];

			// Channel words; long chip reset drops serial turn-on
			always @(posedge sys_clk) begin
				if (reset || cfg_clear) begin
					cfg_q <= `CSO_CH_RST;
					occ_q <= `CSO_OC_RST;
				end else if (word_take) begin
					if (word_addr == CH_ADDR) begin
						cfg_q <= word_val;
					end
					if (word_addr == OC_ADDR) begin
						occ_q <= word_val;
					end
				end
			end

			// Mode select; fail-safe hands control to the direct pin
			always @* begin
				case (mode)
				`CSO_MODE_DIRECT: want = din_s_q[g];
				`CSO_MODE_INTCLK: want = spi_on;
				`CSO_MODE_INTPWM: want = spi_on && (int_phase_q < duty);
				`CSO_MODE_EXTCLK: want = spi_on && (ext_phase_q < duty);
				default:          want = 1'b0;
				endcase
				if (fail_safe) begin
					want = din_s_q[g];
				end
			end

			// Gate drive and track-and-hold sample while on
			// Sampling every on cycle leaves the last one before turn-off held
			always @(posedge sys_clk) begin
				if (reset) begin
					sw_q   <= 1'b0;
					held_q <= {`CSO_CODE_W{1'b0}};
				end else begin
					sw_q <= want;
					if (sw_q) begin
						held_q <= cur;
					end
				end
			end

			// Held code only while off; a live code would read zero load current
			assign switch_output[g] = sw_q;
			assign present_all[g*`CSO_CODE_W +: `CSO_CODE_W] =
				(!sw_q && gcr_q[`CSO_GCR_TH_EN]) ? held_q : cur;

			cso_oc_profile #(
				.UNIT_CYC (OC_UNIT_CYC)
			) u_oc (
				.sys_clk     (sys_clk),
				.reset       (reset),
				.sw_on       (sw_q),
				.motor_load  (cfg_q[`CSO_CH_MOTOR]),
				.win_en      (cfg_q[`CSO_CH_WIN_EN]),
				.step_height (occ_q[`CSO_OC_HGT_HI:`CSO_OC_HGT_LO]),
				.step_len    (occ_q[`CSO_OC_LEN_HI:`CSO_OC_LEN_LO]),
				.oc_window   (oc_window[g]),
				.oc_thresh   (thresh_all[g*`CSO_CODE_W +: `CSO_CODE_W])
			);
		end
	endgenerate

	// Per-channel thresholds back out to their own ports
	assign oc_thresh0 = thresh_all[`CSO_CODE_W-1:0];
	assign oc_thresh1 = thresh_all[2*`CSO_CODE_W-1:`CSO_CODE_W];

	// ==========================================
	// Sense output selection and blanking
	// Blanking wins over select and held value alike
	assign sel_cfg = {gcr_q[`CSO_GCR_SEL_HI], gcr_q[`CSO_GCR_SEL_LO]};
	assign blank   = (|oc_window) || fail_safe || !vdd_s_q;

	always @(posedge sys_clk) begin
		if (reset) begin
			sense_oe    <= 1'b0;
			sense_sel   <= `CSO_SNS_OFF;
			sense_value <= {`CSO_CODE_W{1'b0}};
		end else begin
			sense_sel <= sel_cfg;
			sense_oe  <= (sel_cfg != `CSO_SNS_OFF) && !blank;
			case (sel_cfg)
			`CSO_SNS_CH0:  sense_value <= present_all[`CSO_CODE_W-1:0];
			`CSO_SNS_CH1:  sense_value <=
				present_all[2*`CSO_CODE_W-1:`CSO_CODE_W];
			`CSO_SNS_TEMP: sense_value <= temp_code;
			default:       sense_value <= {`CSO_CODE_W{1'b0}};
			endcase
		end
	end

endmodule

// [rtl/cso_defines.vh]
// Constants for the current sense output control block.
// Assumes a 100 MHz sys_clk and a 16-bit serial word from the host.
`ifndef CSO_DEFINES_VH
`define CSO_DEFINES_VH

// ==========================================
// Timing
`define CSO_CLK_MHZ      100
`define CSO_WDTO_MS      310
`define CSO_WDTO_CYC     (`CSO_WDTO_MS * 1000 * `CSO_CLK_MHZ)
`define CSO_WDTO_W       25
`define CSO_RST_MIN_US   10
`define CSO_RST_MIN_CYC  (`CSO_RST_MIN_US * `CSO_CLK_MHZ)
`define CSO_RST_CNT_W    11
`define CSO_OC_UNIT_US   1000
`define CSO_OC_UNIT_CYC  (`CSO_OC_UNIT_US * `CSO_CLK_MHZ)
`define CSO_OC_UNIT_W    17
`define CSO_PWM_TICK     8'hfa

// ==========================================
// Serial word layout
`define CSO_WORD_W       16
`define CSO_BITS_W       5
`define CSO_TOG_BIT      15
`define CSO_ADDR_HI      12
`define CSO_ADDR_LO      9
`define CSO_DATA_W       9
`define CSO_ADDR_GCR     4'h1
`define CSO_ADDR_CH0     4'h2
`define CSO_ADDR_OC0     4'h4

// ==========================================
// Register fields and reset values
`define CSO_GCR_SEL_LO   0
`define CSO_GCR_SEL_HI   1
`define CSO_GCR_TH_EN    2
`define CSO_GCR_WD_OFF   3
`define CSO_GCR_RST      9'h000
`define CSO_CH_ON        0
`define CSO_CH_MODE_LO   1
`define CSO_CH_MODE_HI   2
`define CSO_CH_MOTOR     3
`define CSO_CH_WIN_EN    4
`define CSO_CH_DUTY_LO   5
`define CSO_CH_DUTY_HI   8
`define CSO_CH_RST       9'h000
`define CSO_OC_HGT_LO    0
`define CSO_OC_HGT_HI    3
`define CSO_OC_LEN_LO    4
`define CSO_OC_LEN_HI    7
`define CSO_OC_RST       9'h011

// ==========================================
// Encodings
`define CSO_MODE_DIRECT  2'h0
`define CSO_MODE_INTCLK  2'h1
`define CSO_MODE_INTPWM  2'h2
`define CSO_MODE_EXTCLK  2'h3
`define CSO_SNS_OFF      2'h0
`define CSO_SNS_CH0      2'h1
`define CSO_SNS_CH1      2'h2
`define CSO_SNS_TEMP     2'h3
`define CSO_OC_STEPS     2'h3
`define CSO_OC_BASE      8'h10
`define CSO_CODE_W       8

`endif

// [rtl/cso_spi_rx.v]
// Serial word receiver for the sense control block.
// Assumes sclk, select_n and si are pins sampled by sys_clk, far slower.
`timescale 1ns/1ps
`include "cso_defines.vh"

module cso_spi_rx (
	input  wire                   sys_clk,    // System clock
	input  wire                   reset,      // Sync reset, active high
	input  wire                   spi_sclk,   // Serial clock pin
	input  wire                   select_n,   // Chip select pin, active low
	input  wire                   spi_si,     // Serial data pin
	output reg                    word_valid, // One-cycle pulse, word done
	output reg  [`CSO_WORD_W-1:0] word_data   // Last complete word
);

	reg                   sclk_m_q, sclk_s_q, sclk_p_q;
	reg                   sel_m_q, sel_s_q, sel_p_q;
	reg                   si_m_q, si_s_q;
	reg [`CSO_WORD_W-1:0] shift_q;
	reg [`CSO_BITS_W-1:0] cnt_q;
	wire                  sclk_fall;
	wire                  sel_rise;

	assign sclk_fall = sclk_p_q & ~sclk_s_q;
	assign sel_rise  = ~sel_p_q & sel_s_q;

	// ==========================================
	// Pin synchronisers, second stage feeds logic
	always @(posedge sys_clk) begin
		if (reset) begin
			{sclk_m_q, sclk_s_q, sclk_p_q} <= 3'h0;
			{sel_m_q, sel_s_q, sel_p_q}    <= 3'h7;
			{si_m_q, si_s_q}               <= 2'h0;
		end else begin
			sclk_m_q <= spi_sclk;
			sclk_s_q <= sclk_m_q;
			sclk_p_q <= sclk_s_q;
			sel_m_q  <= select_n;
			sel_s_q  <= sel_m_q;
			sel_p_q  <= sel_s_q;
			si_m_q   <= spi_si;
			si_s_q   <= si_m_q;
		end
	end

	// ==========================================
	// Shift on sclk fall, deliver on select rise
	// Words of the wrong length are dropped whole
	always @(posedge sys_clk) begin
		if (reset) begin
			shift_q    <= {`CSO_WORD_W{1'b0}};
			cnt_q      <= {`CSO_BITS_W{1'b0}};
			word_valid <= 1'b0;
			word_data  <= {`CSO_WORD_W{1'b0}};
		end else begin
			word_valid <= 1'b0;
			if (sel_s_q) begin
				cnt_q <= {`CSO_BITS_W{1'b0}};
			end else if (sclk_fall) begin
				shift_q <= {shift_q[`CSO_WORD_W-2:0], si_s_q};
				if (cnt_q != {`CSO_BITS_W{1'b1}}) begin
					cnt_q <= cnt_q + 5'h01;
				end
			end
			if (sel_rise && cnt_q == `CSO_WORD_W) begin
				word_valid <= 1'b1;
				word_data  <= shift_q;
			end
		end
	end

endmodule

// [rtl/cso_oc_profile.v]
// Overcurrent threshold profile for one channel.
// Assumes sw_on is a registered switch state on sys_clk.
`timescale 1ns/1ps
`include "cso_defines.vh"

module cso_oc_profile #(
	parameter [`CSO_OC_UNIT_W-1:0] UNIT_CYC = `CSO_OC_UNIT_CYC
) (
	input  wire                  sys_clk,     // System clock
	input  wire                  reset,       // Sync reset, active high
	input  wire                  sw_on,       // Channel switched on
	input  wire                  motor_load,  // 1 motor profile, 0 bulb
	input  wire                  win_en,      // Motor window enable
	input  wire [3:0]            step_height, // Threshold step height
	input  wire [3:0]            step_len,    // Step length in units, minus one
	output reg                   oc_window,   // Profile window active
	output reg  [`CSO_CODE_W-1:0] oc_thresh   // Threshold code
);

	reg                      on_p_q;
	reg [`CSO_OC_UNIT_W-1:0] unit_q;
	reg [3:0]                len_q;
	reg [1:0]                level_q;
	reg [1:0]                level_d;
	wire                     unit_done;
	wire                     step_done;

	assign unit_done = (unit_q == UNIT_CYC - 1'b1);
	assign step_done = unit_done && (len_q == step_len);

	// Next level: bulbs walk down one stair, motors drop at once
	always @* begin
		level_d = level_q;
		if (!sw_on) begin
			level_d = 2'h0;
		end else if (!on_p_q) begin
			level_d = (motor_load && !win_en) ? 2'h0 : `CSO_OC_STEPS;
		end else if (step_done && level_q != 2'h0) begin
			level_d = motor_load ? 2'h0 : level_q - 2'h1;
		end
	end

	// ==========================================
	// Step timer and registered outputs
	always @(posedge sys_clk) begin
		if (reset) begin
			on_p_q    <= 1'b0;
			unit_q    <= {`CSO_OC_UNIT_W{1'b0}};
			len_q     <= 4'h0;
			level_q   <= 2'h0;
			oc_window <= 1'b0;
			oc_thresh <= `CSO_OC_BASE;
		end else begin
			on_p_q  <= sw_on;
			level_q <= level_d;
			if (!sw_on || !on_p_q || unit_done) begin
				unit_q <= {`CSO_OC_UNIT_W{1'b0}};
			end else begin
				unit_q <= unit_q + 1'b1;
			end
			if (!sw_on || !on_p_q || step_done) begin
				len_q <= 4'h0;
			end else if (unit_done) begin
				len_q <= len_q + 4'h1;
			end
			oc_window <= (level_d != 2'h0);
			// Six-bit product: top level times top height must not wrap
			oc_thresh <= `CSO_OC_BASE + ({4'h0, level_d} * {2'h0, step_height});
		end
	end

endmodule

// [tb/cso_sense_ctrl_properties.sv]
// Port checker for cso_sense_ctrl.
// Assumes one sys_clk domain; bound to every instance.
`timescale 1ns/1ps
`include "cso_defines.vh"
module cso_sense_props #(
	parameter [`CSO_WDTO_W-1:0] WDTO_CYC = `CSO_WDTO_CYC
) (
	input wire                   sys_clk,       // Clock
	input wire                   reset,         // Sync reset
	input wire                   chip_reset_n,  // Chip reset pin
	input wire [1:0]             direct_in,     // Direct pins
	input wire                   vdd_present,   // Supply flag
	input wire [`CSO_CODE_W-1:0] temp_code,     // Temperature
	input wire [1:0]             switch_output, // Gate drive
	input wire                   fail_safe,     // Fail-safe
	input wire                   sense_oe,      // Sense driven
	input wire [1:0]             sense_sel,     // Mux select
	input wire [`CSO_CODE_W-1:0] sense_value,   // Sense value
	input wire [1:0]             oc_window      // OC windows
);
	reg [`CSO_WDTO_W-1:0] up_cnt_q;  // Cycles since chip reset rose
	reg [10:0]            low_cnt_q; // Cycles of chip reset low
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// ==========================================
	// Helper counters, saturating so they never wrap
	always @(posedge sys_clk) begin
		if (reset || !chip_reset_n)
			up_cnt_q <= 'h0;
		else if (up_cnt_q != WDTO_CYC)
			up_cnt_q <= up_cnt_q + 'h1;
		if (reset || chip_reset_n)
			low_cnt_q <= 11'h0;
		else if (low_cnt_q != 11'h7ff)
			low_cnt_q <= low_cnt_q + 11'h1;
	end
	// ==========================================
	// Assertions
	a_window_blanks: assert property (|oc_window |=> !sense_oe)
		else $error("sense driven during window");
	a_failsafe_mute: assert property (fail_safe |=> !sense_oe)
		else $error("sense driven in fail-safe");
	a_sel_tristate: assert property (sense_sel == 2'h0 && $past(sense_sel) == 2'h0 |-> !sense_oe)
		else $error("sense not tristated");
	a_supply_gone: assert property (!vdd_present [*4] |=> !sense_oe)
		else $error("sense driven without supply");
	a_temp_route: assert property (sense_oe && sense_sel == 2'h3 && $past(sense_sel) == 2'h3
		|-> sense_value == $past(temp_code))
		else $error("temperature not routed");
	a_wd_interval: assert property ($rose(fail_safe) |-> up_cnt_q == WDTO_CYC)
		else $error("fail-safe too early");
	a_failsafe_clear: assert property (!chip_reset_n [*4] |-> !fail_safe)
		else $error("fail-safe kept in chip reset");
	a_failsafe_pins: assert property ((fail_safe && $stable(direct_in)) [*5]
		|-> switch_output == direct_in)
		else $error("direct pins ignored in fail-safe");
	a_long_reset_off: assert property (low_cnt_q == 11'd1010 && direct_in == 2'h0
		&& $past(direct_in, 4) == 2'h0 |-> switch_output == 2'h0)
		else $error("channel on after long reset");
	// Main scenarios reached
	cover property ($rose(fail_safe));
	cover property (|oc_window ##1 !sense_oe);
	cover property (sense_oe && sense_sel == 2'h3);
endmodule

bind cso_sense_ctrl cso_sense_props #(.WDTO_CYC(WDTO_CYC)) i_cso_sense_props (
	.sys_clk(sys_clk), .reset(reset), .chip_reset_n(chip_reset_n),
	.direct_in(direct_in), .vdd_present(vdd_present), .temp_code(temp_code),
	.switch_output(switch_output), .fail_safe(fail_safe), .sense_oe(sense_oe),
	.sense_sel(sense_sel), .sense_value(sense_value), .oc_window(oc_window));

// [tb/cso_host_model.sv]
// Host model: sends 16-bit words over the serial pins.
// Assumes sys_clk paces the link; sclk period 160 ns.
`timescale 1ns/1ps
module cso_host_model (
	input  wire sys_clk,  // Pacing clock
	output reg  spi_sclk, // Link clock, still between words
	output reg  select_n, // Chip select, active low
	output reg  spi_si    // Data, pull-down level when idle
);
	reg tog_q;    // First word bit
	reg freeze_q; // Stops alternation to fake a lost host
	initial begin
		spi_sclk = 1'b0;
		select_n = 1'b1;
		spi_si = 1'b0;
		tog_q = 1'b0;
		freeze_q = 1'b0;
	end
	// One word, MSB first, data changed while sclk high
	task send_word(input [14:0] body);
		integer i;
		begin
			if (!freeze_q)
				tog_q = ~tog_q;
			@(negedge sys_clk);
			select_n = 1'b0;
			for (i = 15; i >= 0; i = i - 1) begin
				repeat (8) @(negedge sys_clk);
				spi_sclk = 1'b1;
				repeat (4) @(negedge sys_clk);
				spi_si = (i == 15) ? tog_q : body[i];
				repeat (4) @(negedge sys_clk);
				spi_sclk = 1'b0;
			end
			repeat (8) @(negedge sys_clk);
			select_n = 1'b1;
			spi_si = 1'b0;
			repeat (8) @(negedge sys_clk);
		end
	endtask
endmodule

// [tb/cso_testbench.sv]
// Bench for cso_sense_ctrl with a host model on the serial pins.
// Assumes shortened watchdog and profile unit parameters.
`timescale 1ns/1ps
`include "cso_defines.vh"
`define CHK(nm, ex, got) begin compares = compares + 1; if ((got) !== (ex)) begin \
	mismatches = mismatches + 1; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module testbench;
	reg        sys_clk, reset, chip_reset_n, ext_clk, vdd_present;
	reg  [1:0] direct_in;
	reg  [7:0] code0, code1, tcode;
	wire       spi_sclk, select_n, spi_si, fail_safe, sense_oe;
	wire [1:0] switch_output, sense_sel, oc_window;
	wire [7:0] sense_value, oc_thresh0, oc_thresh1;
	integer    mismatches, compares, s, hi;
	cso_host_model i_cso_host_model (.sys_clk(sys_clk), .spi_sclk(spi_sclk),
		.select_n(select_n), .spi_si(spi_si));
	cso_sense_ctrl #(.WDTO_CYC(25'd2000), .OC_UNIT_CYC(17'd20)) i_cso_sense_ctrl (
		.sys_clk(sys_clk), .reset(reset), .chip_reset_n(chip_reset_n),
		.spi_sclk(spi_sclk), .select_n(select_n), .spi_si(spi_si),
		.direct_in(direct_in), .ext_clk(ext_clk), .vdd_present(vdd_present),
		.current_code0(code0), .current_code1(code1), .temp_code(tcode),
		.switch_output(switch_output), .fail_safe(fail_safe), .sense_oe(sense_oe),
		.sense_sel(sense_sel), .sense_value(sense_value), .oc_window(oc_window),
		.oc_thresh0(oc_thresh0), .oc_thresh1(oc_thresh1));
	// ==========================================
	// Clocks; ext_clk edges land on falling sys_clk edges
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		ext_clk = 1'b0;
		forever #2500 ext_clk = ~ext_clk;
	end
	task cyc(input integer n);
		repeat (n) @(negedge sys_clk);
	endtask
	task wr(input [3:0] a, input [8:0] d);
		i_cso_host_model.send_word({2'h0, a, d});
	endtask
	// Cycles with channel 1 on over a window of n cycles
	task count_on(input integer n, output integer cnt);
		begin
			cnt = 0;
			repeat (n) begin
				@(negedge sys_clk);
				cnt = cnt + switch_output[1];
			end
		end
	endtask
	task stop_test;
		begin
			$display("mismatches %0d compares %0d", mismatches, compares);
			if (mismatches == 0 && compares > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// Hang guard, well beyond the ~22k cycles of the sequence
	initial begin
		cyc(40000);
		mismatches = mismatches + 1;
		stop_test;
	end
	// ==========================================
	// Main sequence
	initial begin
		mismatches = 0; compares = 0; reset = 1'b1; chip_reset_n = 1'b0;
		direct_in = 2'h0; vdd_present = 1'b1; code0 = 8'h5a; code1 = 8'ha5; tcode = 8'h3c;
		cyc(12);
		reset = 1'b0;
		cyc(1);
		`CHK("oe_rst", 1'b0, sense_oe)
		`CHK("thr_rst", 8'h10, oc_thresh0)
		`CHK("thr1_rst", 8'h10, oc_thresh1)
		chip_reset_n = 1'b1;
		cyc(10);
		// Every selection, watchdog disabled
		for (s = 0; s < 4; s = s + 1) begin
			wr(`CSO_ADDR_GCR, 9'h008 | s[8:0]);
			`CHK("sel", s[1:0], sense_sel)
			`CHK("oe", (s != 0), sense_oe)
			if (s != 0)
				`CHK("val", (s == 1) ? code0 : (s == 2) ? code1 : tcode, sense_value)
		end
		vdd_present = 1'b0;
		cyc(6);
		`CHK("oe_vdd", 1'b0, sense_oe)
		vdd_present = 1'b1;
		cyc(6);
		`CHK("oe_vdd1", 1'b1, sense_oe)
		// Bulb staircase, height 2, one unit per step
		wr(`CSO_ADDR_OC0, 9'h002);
		wr(`CSO_ADDR_GCR, 9'h009);
		wr(`CSO_ADDR_CH0, 9'h003);
		`CHK("sw_on", 1'b1, switch_output[0])
		`CHK("win", 1'b1, oc_window[0])
		`CHK("thr3", 8'h16, oc_thresh0)
		`CHK("oe_win", 1'b0, sense_oe)
		cyc(20);
		`CHK("thr2", 8'h14, oc_thresh0)
		cyc(50);
		`CHK("win0", 1'b0, oc_window[0])
		`CHK("thr0", 8'h10, oc_thresh0)
		`CHK("oe_nowin", 1'b1, sense_oe)
		// Track-and-hold keeps the last on value
		code0 = 8'h77;
		wr(`CSO_ADDR_GCR, 9'h00d);
		wr(`CSO_ADDR_CH0, 9'h000);
		code0 = 8'h11;
		cyc(4);
		`CHK("hold", 8'h77, sense_value)
		// Motor window, then motor without window
		wr(`CSO_ADDR_OC0, 9'h001);
		wr(`CSO_ADDR_CH0, 9'h01b);
		`CHK("mwin", 1'b1, oc_window[0])
		cyc(30);
		`CHK("mwin0", 1'b0, oc_window[0])
		wr(`CSO_ADDR_CH0, 9'h000);
		wr(`CSO_ADDR_CH0, 9'h00b);
		`CHK("nowin", 1'b0, oc_window[0])
		// Channel 1 PWM modes: one full period holds exactly duty phases on
		wr(`CSO_ADDR_CH0 + 4'h1, 9'h105);
		count_on(16 * `CSO_PWM_TICK, hi);
		`CHK("pwm_int", 8 * `CSO_PWM_TICK, hi)
		// External phase lasts one ext_clk period of 500 cycles
		wr(`CSO_ADDR_CH0 + 4'h1, 9'h087);
		count_on(8000, hi);
		`CHK("pwm_ext", 2000, hi)
		`CHK("wd_off", 1'b0, fail_safe)
		// Long chip reset clears a serially set channel and config
		wr(`CSO_ADDR_CH0, 9'h003);
		chip_reset_n = 1'b0;
		cyc(1010);
		`CHK("rst_off", 2'h0, switch_output)
		chip_reset_n = 1'b1;
		cyc(10);
		`CHK("sel_def", 2'h0, sense_sel)
		cyc(1700);
		`CHK("fs_early", 1'b0, fail_safe)
		// Kick lands about 270 cycles on, inside the 2000-cycle limit
		wr(`CSO_ADDR_GCR, 9'h003);
		cyc(100);
		`CHK("fs_kept", 1'b0, fail_safe)
		i_cso_host_model.freeze_q = 1'b1;
		wr(`CSO_ADDR_GCR, 9'h003);
		cyc(1600);
		`CHK("fs_wait", 1'b0, fail_safe)
		cyc(200);
		`CHK("fs_on", 1'b1, fail_safe)
		`CHK("oe_fs", 1'b0, sense_oe)
		direct_in = 2'h2;
		cyc(6);
		`CHK("fs_pin", 2'h2, switch_output)
		direct_in = 2'h0;
		// Short chip reset leaves fail-safe, keeps config
		chip_reset_n = 1'b0;
		cyc(10);
		`CHK("fs_clr", 1'b0, fail_safe)
		chip_reset_n = 1'b1;
		cyc(5);
		`CHK("sel_kept", 2'h3, sense_sel)
		stop_test;
	end
endmodule
